// file: logic/fbrd_consts.svh
// Offsets, field positions and reset values of the frame buffer read port
// Summary of operation
// - Storage is reached as 64-bit quad words through the upper 15 address bits.
// - Each fetched quad word is unpacked into a sixteen-byte FIFO for host reads.
// - Request field bits 4:3: 01 audio, 10 video, 11 host write, 00 none.
// - Error conditions are latched in an error status register for the host.
// - Audio region starts at 0x7E00 (256KB) or 0x3E00 (128KB); below is video.
// - Fetch-complete flag sets once the quad word sits in the FIFO.
// - Reads of 0xCC return successive bytes while the address advances internally.
// - Without wrap, video reads at top set buffer end; restart resumes at zero.
// - With wrap mode on, the video read address wraps on its own.
// - Video byte address: top 15 bits go to storage, low 3 pick first byte; host writes use only the top 15.
// - Burst register accesses increment the register address after every byte, except at ports 0xCC and 0x56.
// - An audio read pointer resumes audio where the previous transfer stopped.
// - Emptying the audio buffer clears the request field.
// - Bytes to the write data port gather into 64 bits, then write once.
`ifndef FBRD_CONSTS_SVH
`define FBRD_CONSTS_SVH

`define FB_REG_STATUS 8'h20
`define FB_REG_READ_PORT 8'hCC
`define FB_REG_WDATA 8'h56
`define FB_REG_ADDR_LO 8'h58
`define FB_REG_ADDR_HI 8'h59
`define FB_REG_CTRL 8'h5A
`define FB_REG_ERR 8'h5B
`define FB_REG_APTR_LO 8'h5C
`define FB_REG_APTR_HI 8'h5D

`define FB_CTRL_REQ_HI 4
`define FB_CTRL_REQ_LO 3
`define FB_CTRL_DONE 7
`define FB_STAT_END 0
`define FB_STAT_RESTART 1
`define FB_STAT_WRAP 2
`define FB_STAT_LFC 3
`define FB_STAT_CFC 4
`define FB_ERR_EMPTY 0
`define FB_ERR_WRITE 1
`define FB_ERR_NOCAP 2

`define FB_AUDIO_START_256K 15'h7E00
`define FB_AUDIO_START_128K 15'h3E00
`define FB_QW_LAST_256K 15'h7FFF
`define FB_QW_LAST_128K 15'h3FFF
`define FB_QW_BYTES 8
`define FB_BYTE_RESET 8'h00
`define FB_QW_RESET 15'h0000

`endif

// file: logic/fbrd_pkg.sv
// Types shared by the frame buffer read port
`default_nettype none
package fbrd_pkg;
   typedef enum logic [1:0] {
      REQ_NONE = 2'b00,
      REQ_AUDIO = 2'b01,
      REQ_VIDEO = 2'b10,
      REQ_WRITE = 2'b11
   } req_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_WRITE = 2'b10
   } state_t;
endpackage : fbrd_pkg
`default_nettype wire

// file: logic/qword_byte_fifo.sv
// Byte FIFO loaded a quad word at a time, drained a byte at a time
`timescale 1ns/1ps
`default_nettype none
module qword_byte_fifo #(
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic flush,
   input wire logic load,
   input wire logic [63:0] load_word,
   input wire logic [2:0] load_first,
   input wire logic pop,
   output logic [7:0] head,
   output logic [AW:0] count,
   output logic empty
);
   logic [7:0] mem [DEPTH];
   logic [AW-1:0] rd_q;
   logic [AW-1:0] wr_q;
   logic [AW:0] cnt_q;
   wire logic do_pop = pop && (cnt_q != '0);
   wire logic [AW:0] n_load = load ? (AW+1)'(4'd8 - {1'b0, load_first}) : '0;

   if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("FIFO depth must be a power of two of at least 16");
   end

   assign head = mem[rd_q];
   assign count = cnt_q;
   assign empty = (cnt_q == '0);

   // Bytes below the start offset of a quad word are skipped on load
   always_ff @(posedge clk) begin
      for (int i = 0; i < 8; i++) begin
         if (load && i >= load_first) begin
            mem[wr_q + AW'(i - load_first)] <= load_word[8*i +: 8];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || flush) begin
         rd_q <= '0;
         wr_q <= '0;
         cnt_q <= '0;
      end else begin
         rd_q <= rd_q + AW'(do_pop);
         wr_q <= wr_q + n_load[AW-1:0];
         cnt_q <= cnt_q + n_load - (AW+1)'(do_pop);
      end
   end
endmodule : qword_byte_fifo
`default_nettype wire

// file: logic/host_frame_buffer_read_port.sv
// Host access to the frame store: fetch, unpack, byte reads and gathered writes
`timescale 1ns/1ps
`default_nettype none
`include "fbrd_consts.svh"
module host_frame_buffer_read_port #(
   parameter bit BIG_BUFFER = 1'b1,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic REG_START,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   output logic FS_REQ,
   output logic FS_WE,
   output logic [14:0] FS_ADDR,
   output logic [63:0] FS_WDATA,
   input wire logic FS_ACK,
   input wire logic [63:0] FS_RDATA,
   input wire logic [14:0] AUD_WR_PTR
);
   localparam int AW = $clog2(FIFO_DEPTH);
   localparam logic [14:0] AUD_START = BIG_BUFFER ? `FB_AUDIO_START_256K : `FB_AUDIO_START_128K;
   localparam logic [14:0] AUD_LAST = BIG_BUFFER ? `FB_QW_LAST_256K : `FB_QW_LAST_128K;
   localparam logic [14:0] VID_LAST = AUD_START - 15'h0001;

   fbrd_pkg::state_t state_q, state_d;
   fbrd_pkg::req_t req_q;
   logic [7:0] reg_addr_q, addr_lo_q, addr_hi_q;
   logic [2:0] first_q, err_q;
   logic [14:0] qaddr_q, aptr_q;
   logic [63:0] gather_q;
   logic [2:0] gcnt_q;
   logic done_q, end_q, wrap_q, lfc_q, cfc_q, stale_q;
   logic [7:0] head;
   logic [AW:0] fifo_cnt;
   logic fifo_empty;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction : hit

   // Decode of the host register strobes
   wire logic [7:0] ra = reg_addr_q;
   wire logic [1:0] wr_req = REG_WDATA[`FB_CTRL_REQ_HI:`FB_CTRL_REQ_LO];
   wire logic capt_on = lfc_q || cfc_q;
   wire logic wr_ctrl = REG_WR && hit(ra, `FB_REG_CTRL);
   wire logic new_req = wr_ctrl && wr_req != 2'b00 && capt_on;
   wire logic rd_port = REG_RD && hit(ra, `FB_REG_READ_PORT);
   wire logic pop = rd_port && !fifo_empty;
   wire logic restart = REG_WR && hit(ra, `FB_REG_STATUS) && REG_WDATA[`FB_STAT_RESTART];
   wire logic wr_byte = REG_WR && hit(ra, `FB_REG_WDATA);
   wire logic byte_ok = wr_byte && req_q == fbrd_pkg::REQ_WRITE && state_q == fbrd_pkg::ST_IDLE;
   wire logic last_byte = byte_ok && gcnt_q == 3'd7;
   wire logic audio_dry = (aptr_q == AUD_WR_PTR);
   wire logic room = fifo_cnt <= (AW+1)'(FIFO_DEPTH - `FB_QW_BYTES);
   wire logic want_vid = req_q == fbrd_pkg::REQ_VIDEO && !end_q;
   wire logic want_aud = req_q == fbrd_pkg::REQ_AUDIO && !audio_dry;
   wire logic start_fetch = state_q == fbrd_pkg::ST_IDLE && !new_req && room && (want_vid || want_aud);
   // Answer to a fetch overtaken by a new request is dropped, never unpacked
   wire logic ack_any = state_q == fbrd_pkg::ST_FETCH && FS_ACK;
   wire logic ack_rd = ack_any && !stale_q && !new_req;
   wire logic stale_d = state_q == fbrd_pkg::ST_FETCH && !FS_ACK && (new_req || stale_q);
   wire logic ack_wr = state_q == fbrd_pkg::ST_WRITE && FS_ACK;
   wire logic ack_vid = ack_rd && req_q == fbrd_pkg::REQ_VIDEO;
   wire logic ack_aud = ack_rd && req_q == fbrd_pkg::REQ_AUDIO;
   wire logic vid_top = qaddr_q == VID_LAST;
   wire logic set_end = ack_vid && vid_top && !wrap_q;
   wire logic aud_done = req_q == fbrd_pkg::REQ_AUDIO && fifo_empty && audio_dry
                         && state_q == fbrd_pkg::ST_IDLE && !new_req;
   wire logic rd_err = REG_RD && hit(ra, `FB_REG_ERR);
   wire logic [2:0] err_set = {wr_ctrl && wr_req != 2'b00 && !capt_on, wr_byte && !byte_ok, rd_port && fifo_empty};
   wire logic [2:0] err_d = err_set | (err_q & ~{3{rd_err}});
   wire logic end_d = set_end || (end_q && !restart);
   wire logic done_d = ack_rd || (done_q && !new_req);
   wire logic special = hit(ra, `FB_REG_READ_PORT) || hit(ra, `FB_REG_WDATA);
   wire logic [14:0] vid_next = vid_top ? (wrap_q ? `FB_QW_RESET : qaddr_q) : qaddr_q + 15'h0001;
   wire logic [14:0] aud_next = (aptr_q == AUD_LAST) ? AUD_START : aptr_q + 15'h0001;
   wire logic [14:0] start_qw = {addr_hi_q[6:0], addr_lo_q};
   wire logic [7:0] stat_rd = {3'b000, cfc_q, lfc_q, wrap_q, 1'b0, end_q};
   wire logic [7:0] ctrl_rd = {done_q, 2'b00, req_q, first_q};
   wire logic [7:0] rd_mux = hit(ra, `FB_REG_READ_PORT) ? (fifo_empty ? `FB_BYTE_RESET : head)
                           : hit(ra, `FB_REG_STATUS) ? stat_rd
                           : hit(ra, `FB_REG_CTRL) ? ctrl_rd
                           : hit(ra, `FB_REG_ADDR_LO) ? addr_lo_q
                           : hit(ra, `FB_REG_ADDR_HI) ? addr_hi_q
                           : hit(ra, `FB_REG_ERR) ? {5'b00000, err_q}
                           : hit(ra, `FB_REG_APTR_LO) ? aptr_q[7:0]
                           : hit(ra, `FB_REG_APTR_HI) ? {1'b0, aptr_q[14:8]}
                           : `FB_BYTE_RESET;

   qword_byte_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK_SYS),
      .nrst(NRST),
      .flush(new_req),
      .load(ack_rd),
      .load_word(FS_RDATA),
      .load_first(first_q),
      .pop(pop),
      .head(head),
      .count(fifo_cnt),
      .empty(fifo_empty)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         fbrd_pkg::ST_IDLE: begin
            if (start_fetch) state_d = fbrd_pkg::ST_FETCH;
            else if (last_byte) state_d = fbrd_pkg::ST_WRITE;
         end
         fbrd_pkg::ST_FETCH: if (FS_ACK) state_d = fbrd_pkg::ST_IDLE;
         fbrd_pkg::ST_WRITE: if (FS_ACK) state_d = fbrd_pkg::ST_IDLE;
         default: state_d = fbrd_pkg::ST_IDLE;
      endcase
   end

   // Register address: bursts step on, except the two streaming ports
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) reg_addr_q <= `FB_BYTE_RESET;
      else if (REG_START) reg_addr_q <= REG_ADDR;
      else if ((REG_RD || REG_WR) && !special) reg_addr_q <= reg_addr_q + 8'h01;
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         REG_RDATA <= `FB_BYTE_RESET;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD) REG_RDATA <= rd_mux;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         addr_lo_q <= `FB_BYTE_RESET;
         addr_hi_q <= `FB_BYTE_RESET;
         {wrap_q, lfc_q, cfc_q} <= 3'b000;
      end else if (REG_WR) begin
         if (hit(ra, `FB_REG_ADDR_LO)) addr_lo_q <= REG_WDATA;
         if (hit(ra, `FB_REG_ADDR_HI)) addr_hi_q <= {1'b0, REG_WDATA[6:0]};
         if (hit(ra, `FB_REG_STATUS)) begin
            wrap_q <= REG_WDATA[`FB_STAT_WRAP];
            lfc_q <= REG_WDATA[`FB_STAT_LFC];
            cfc_q <= REG_WDATA[`FB_STAT_CFC];
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         state_q <= fbrd_pkg::ST_IDLE;
         err_q <= 3'b000;
         end_q <= 1'b0;
         done_q <= 1'b0;
         stale_q <= 1'b0;
      end else begin
         state_q <= state_d;
         stale_q <= stale_d;
         err_q <= err_d;
         end_q <= end_d;
         done_q <= done_d;
      end
   end

   // Request, offsets and the two fetch addresses
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         req_q <= fbrd_pkg::REQ_NONE;
         first_q <= 3'b000;
         qaddr_q <= `FB_QW_RESET;
         aptr_q <= AUD_START;
      end else if (new_req) begin
         req_q <= fbrd_pkg::req_t'(wr_req);
         first_q <= (wr_req == fbrd_pkg::REQ_VIDEO) ? REG_WDATA[2:0] : 3'b000;
         qaddr_q <= start_qw;
      end else begin
         if (aud_done) req_q <= fbrd_pkg::REQ_NONE;
         if (ack_rd) first_q <= 3'b000;
         if (ack_vid) qaddr_q <= vid_next;
         else if (ack_wr) qaddr_q <= qaddr_q + 15'h0001;
         else if (restart) qaddr_q <= `FB_QW_RESET;
         if (ack_aud) aptr_q <= aud_next;
      end
   end

   // Write bytes land lowest lane first
   always_ff @(posedge CLK_SYS) begin
      if (!NRST || new_req) begin
         gather_q <= '0;
         gcnt_q <= 3'b000;
      end else if (byte_ok) begin
         gather_q[8*gcnt_q +: 8] <= REG_WDATA;
         gcnt_q <= gcnt_q + 3'b001;
      end
   end

   // Storage port: request held until acknowledged
   always_ff @(posedge CLK_SYS) begin
      if (!NRST) begin
         FS_REQ <= 1'b0;
         FS_WE <= 1'b0;
         FS_ADDR <= `FB_QW_RESET;
         FS_WDATA <= '0;
      end else if (start_fetch) begin
         FS_REQ <= 1'b1;
         FS_WE <= 1'b0;
         FS_ADDR <= want_aud ? aptr_q : qaddr_q;
      end else if (last_byte) begin
         FS_REQ <= 1'b1;
         FS_WE <= 1'b1;
         FS_ADDR <= qaddr_q;
         FS_WDATA <= {REG_WDATA, gather_q[55:0]};
      end else if (FS_ACK) begin
         FS_REQ <= 1'b0;
         FS_WE <= 1'b0;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);

   sequence s_eighth_byte;
      last_byte && state_q == fbrd_pkg::ST_IDLE;
   endsequence
   sequence s_audio_drained;
      aud_done ##1 1'b1;
   endsequence

   req_hold_a: assert property (FS_REQ && !FS_ACK |=> FS_REQ && $stable(FS_ADDR) && $stable(FS_WE))
      else $error("storage request dropped or changed before ack");
   unpack_count_a: assert property (ack_rd && !new_req |=>
      fifo_cnt == $past(fifo_cnt) + (AW+1)'(4'd8 - {1'b0, $past(first_q)}) - (AW+1)'($past(pop)))
      else $error("fifo did not take the bytes of the quad word");
   done_flag_a: assert property (ack_rd |=> done_q && ctrl_rd[`FB_CTRL_DONE])
      else $error("fetch complete flag not set after fetch");
   stale_drop_a: assert property (stale_q && FS_ACK |=> !done_q && fifo_empty)
      else $error("answer of an overtaken fetch was used");
   buffer_end_a: assert property (set_end |=> end_q && state_q == fbrd_pkg::ST_IDLE ##1 !FS_REQ || restart)
      else $error("buffer end not flagged at top of video space");
   wrap_addr_a: assert property (ack_vid && vid_top && wrap_q && !new_req |=> qaddr_q == 15'h0000)
      else $error("video address did not wrap");
   empty_read_a: assert property (rd_port && fifo_empty |=> err_q[`FB_ERR_EMPTY] && fifo_cnt <= $past(fifo_cnt) + 8)
      else $error("empty port read not reported");
   burst_step_a: assert property ((REG_RD || REG_WR) && !REG_START && !special |=> reg_addr_q == $past(reg_addr_q) + 8'h01)
      else $error("register address did not step in burst");
   port_stays_a: assert property (REG_RD && !REG_START && hit(ra, `FB_REG_READ_PORT) |=> hit(reg_addr_q, `FB_REG_READ_PORT))
      else $error("read port address moved");
   audio_ptr_a: assert property ($rose(FS_REQ) && !FS_WE && req_q == fbrd_pkg::REQ_AUDIO |-> FS_ADDR == aptr_q)
      else $error("audio fetch not at the audio read pointer");
   audio_region_a: assert property (aptr_q >= AUD_START && aptr_q <= AUD_LAST)
      else $error("audio pointer left the audio region");
   audio_clear_a: assert property (s_audio_drained |-> req_q == fbrd_pkg::REQ_NONE)
      else $error("request field not cleared on drained audio");
   gather_write_a: assert property (s_eighth_byte |=> FS_REQ && FS_WE && FS_WDATA[63:56] == $past(REG_WDATA))
      else $error("gathered quad word not written");
endmodule : host_frame_buffer_read_port
`default_nettype wire

// file: sim/frame_store_model.sv
// Behavioural quad-word storage answering the read port's requests
`timescale 1ns/1ps
`default_nettype none
module frame_store_model (
   input wire logic clk,
   input wire logic req,
   input wire logic we,
   input wire logic [14:0] addr,
   input wire logic [63:0] wdata,
   input wire logic [7:0] delay,
   output logic ack,
   output logic [63:0] rdata,
   output logic [14:0] wr_addr,
   output logic [63:0] wr_data,
   output int writes
);
   int wait_n = 0;
   initial begin
      ack = 1'b0;
      rdata = 64'h0;
      wr_addr = 15'h0;
      wr_data = 64'h0;
      writes = 0;
   end
   always @(posedge clk) begin
      ack <= 1'b0;
      // Junk outside an answer so stale data never looks valid
      rdata <= ~rdata;
      if (req && !ack) begin
         if (wait_n >= int'(delay)) begin
            wait_n <= 0;
            ack <= 1'b1;
            if (we) begin
               wr_addr <= addr;
               wr_data <= wdata;
               writes <= writes + 1;
            end else begin
               rdata <= {8{addr[7:0]}} ^ 64'h0706050403020100;
            end
         end else begin
            wait_n <= wait_n + 1;
         end
      end
   end
endmodule : frame_store_model
`default_nettype wire

// file: sim/tb_host_frame_buffer_read_port.sv
// Self-checking bench for the frame buffer read port
`timescale 1ns/1ps
`default_nettype none
`include "fbrd_consts.svh"
module tb_host_frame_buffer_read_port;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic start = 1'b0;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic reg_rd = 1'b0;
   logic [7:0] rdata;
   logic rvalid, fs_req, fs_we, fs_ack;
   logic [14:0] fs_addr, wr_addr;
   logic [63:0] fs_wdata, fs_rdata, wr_data;
   logic [14:0] aud_wr_ptr = `FB_AUDIO_START_256K;
   logic [7:0] delay = 8'h02;
   int writes;
   int fails = 0;
   int tests_run = 0;

   always #2.5 clk = ~clk;

   host_frame_buffer_read_port dut (.CLK_SYS(clk), .NRST(nrst), .REG_START(start), .REG_ADDR(addr),
      .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(reg_rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .FS_REQ(fs_req), .FS_WE(fs_we), .FS_ADDR(fs_addr), .FS_WDATA(fs_wdata), .FS_ACK(fs_ack),
      .FS_RDATA(fs_rdata), .AUD_WR_PTR(aud_wr_ptr));
   frame_store_model store (.clk(clk), .req(fs_req), .we(fs_we), .addr(fs_addr), .wdata(fs_wdata),
      .delay(delay), .ack(fs_ack), .rdata(fs_rdata), .wr_addr(wr_addr), .wr_data(wr_data), .writes(writes));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic set_addr(input logic [7:0] a);
      @(negedge clk) start = 1'b1;
      addr = a;
      @(negedge clk) start = 1'b0;
   endtask : set_addr

   task automatic write_byte(input logic [7:0] d);
      @(negedge clk) wr = 1'b1;
      wdata = d;
      @(negedge clk) wr = 1'b0;
   endtask : write_byte

   task automatic read_byte(output logic [7:0] d);
      @(negedge clk) reg_rd = 1'b1;
      @(negedge clk) reg_rd = 1'b0;
      // Valid lasts one cycle, so it is looked at here
      if (rvalid !== 1'b1) begin
         fails++;
         $display("unexpected at %0t: no read valid", $time);
      end
      d = rdata;
   endtask : read_byte

   task automatic reg_check(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
      logic [7:0] d;
      set_addr(a);
      read_byte(d);
      chk(d & mask, exp);
   endtask : reg_check

   task automatic request(input logic [14:0] qa, input logic [2:0] off, input fbrd_pkg::req_t code);
      set_addr(`FB_REG_ADDR_LO);
      write_byte(qa[7:0]);
      write_byte({1'b0, qa[14:8]});
      write_byte({3'b000, code, off});
   endtask : request

   task automatic wait_done;
      logic [7:0] d;
      int k;
      k = 0;
      d = 8'h00;
      while (d[`FB_CTRL_DONE] !== 1'b1 && k < 100) begin
         set_addr(`FB_REG_CTRL);
         read_byte(d);
         k++;
      end
      chk({7'b0, d[`FB_CTRL_DONE]}, 8'h01);
   endtask : wait_done

   // Video wraps below the audio region; audio streams never wrap here
   task automatic stream(input logic [14:0] qa, input int off, input int n);
      logic [7:0] d;
      logic [14:0] q;
      int p;
      set_addr(`FB_REG_READ_PORT);
      for (int i = 0; i < n; i++) begin
         p = off + i;
         q = qa + 15'(p / 8);
         if (q >= `FB_AUDIO_START_256K && qa < `FB_AUDIO_START_256K) q = q - `FB_AUDIO_START_256K;
         read_byte(d);
         chk(d, q[7:0] ^ 8'(p % 8));
      end
   endtask : stream

   task automatic test_done;
      $display("tests_run %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   initial begin
      #100us;
      fails++;
      $display("unexpected at %0t: watchdog expired", $time);
      test_done();
   end

   initial begin
      int n;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      reg_check(8'h10, 8'hFF, 8'h00);
      reg_check(`FB_REG_ERR, 8'hFF, 8'h00);
      request(15'h0012, 3'd3, fbrd_pkg::REQ_VIDEO);
      repeat (10) @(negedge clk);
      chk({7'b0, fs_req}, 8'h00);
      reg_check(`FB_REG_ERR, 8'hFF, 8'h04);
      $display("test refusal done");
      set_addr(`FB_REG_STATUS);
      write_byte(8'h08);
      request(15'h0012, 3'd3, fbrd_pkg::REQ_VIDEO);
      wait_done();
      stream(15'h0012, 3, 21);
      $display("test video read done");
      delay = 8'd40;
      request(15'h0105, 3'd0, fbrd_pkg::REQ_VIDEO);
      reg_check(`FB_REG_READ_PORT, 8'hFF, 8'h00);
      reg_check(`FB_REG_ERR, 8'hFF, 8'h01);
      wait_done();
      stream(15'h0105, 0, 4);
      delay = 8'd2;
      $display("test empty read done");
      request(15'h7DFF, 3'd0, fbrd_pkg::REQ_VIDEO);
      wait_done();
      stream(15'h7DFF, 0, 8);
      repeat (10) @(negedge clk);
      reg_check(`FB_REG_STATUS, 8'h1F, 8'h09);
      set_addr(`FB_REG_STATUS);
      write_byte(8'h0A);
      reg_check(`FB_REG_STATUS, 8'h1F, 8'h08);
      set_addr(`FB_REG_STATUS);
      write_byte(8'h0C);
      request(15'h7DFF, 3'd6, fbrd_pkg::REQ_VIDEO);
      wait_done();
      stream(15'h7DFF, 6, 12);
      $display("test buffer end done");
      set_addr(`FB_REG_WDATA);
      write_byte(8'h55);
      reg_check(`FB_REG_ERR, 8'hFF, 8'h02);
      request(15'h0040, 3'd0, fbrd_pkg::REQ_WRITE);
      set_addr(`FB_REG_WDATA);
      for (int i = 0; i < 8; i++) write_byte(8'hA0 + 8'(i));
      n = 0;
      while (writes == 0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      tests_run++;
      if (wr_addr !== 15'h0040 || wr_data !== 64'hA7A6A5A4A3A2A1A0) begin
         fails++;
         $display("unexpected at %0t: gathered write wrong", $time);
      end
      $display("test host write done");
      aud_wr_ptr = 15'h7E02;
      set_addr(`FB_REG_CTRL);
      write_byte(8'h08);
      wait_done();
      stream(`FB_AUDIO_START_256K, 0, 16);
      repeat (10) @(negedge clk);
      reg_check(`FB_REG_CTRL, 8'h18, 8'h00);
      reg_check(`FB_REG_APTR_LO, 8'hFF, 8'h02);
      reg_check(`FB_REG_APTR_HI, 8'hFF, 8'h7E);
      $display("test audio done");
      test_done();
   end
endmodule : tb_host_frame_buffer_read_port
`default_nettype wire
